// ==== pkg/brk_consts.svh ====
// Constants of the braking and power-up run sequencer
// Overview of operation
// [RULE_01] Sel 0: power-up run refused until cycled
// [RULE_02] Refused power-up run flashes indicator fast
// [RULE_03] Sel 1: power-up run starts after start-up
// [RULE_04] Power-up select is 0 or 1, resets 0
// [RULE_05] Stop threshold only for ramp-to-stop method
// [RULE_06] DC injection for IM, phase short for PM
// [RULE_07] Ramp stop brakes below start frequency
// [RULE_08] Threshold is larger of start and minimum
// [RULE_09] Minimum frequency 0-400 Hz, clamped to maximum
// [RULE_10] Injection current 0-75 percent, default 50
// [RULE_11] Injection above 50 percent forces 1 kHz
// [RULE_12] Start injection time 0-10 s, 0 disables
// [RULE_13] Stop injection time 0-10 s, default 0.5
// [RULE_14] Flux boost 0-1000 percent, default 0
// [RULE_15] Flux boost below minimum, during start injection
// [RULE_16] Phase short ties all three phases, PM only
// [RULE_17] Start phase short 0-25.5 s, default 0
// [RULE_18] Stop phase short 0-25.5 s, default 0.5
// [RULE_19] DC stop time scales ten times freq ratio
// [RULE_20] Timer end: output off, or run after start
`ifndef BRK_CONSTS_SVH
`define BRK_CONSTS_SVH
`define BRK_CLK_NS        5
`define BRK_TICK_NS       10000000
`define BRK_TICK_CYCLES   (`BRK_TICK_NS / `BRK_CLK_NS)
`define BRK_FLASH_TICKS   8'h0A
`define BRK_A_CTRL        6'h00
`define BRK_A_BRKFREQ     6'h04
`define BRK_A_MINFREQ     6'h08
`define BRK_A_MAXFREQ     6'h0C
`define BRK_A_INJLVL      6'h10
`define BRK_A_INJSTART    6'h14
`define BRK_A_INJSTOP     6'h18
`define BRK_A_FLUX        6'h1C
`define BRK_A_SCSTART     6'h20
`define BRK_A_SCSTOP      6'h24
`define BRK_A_STATUS      6'h28
`define BRK_MAX_BRKFREQ   16'h0064
`define BRK_MAX_FREQ_LIM  16'h0FA0
`define BRK_MAX_INJLVL    16'h004B
`define BRK_CARRIER_LVL   16'h0032
`define BRK_MAX_INJTIME   16'h03E8
`define BRK_MAX_FLUX      16'h03E8
`define BRK_MAX_SCTIME    16'h09F6
`define BRK_RST_BRKFREQ   16'h0005
`define BRK_RST_MINFREQ   16'h000F
`define BRK_RST_MAXFREQ   16'h0258
`define BRK_RST_INJLVL    16'h0032
`define BRK_RST_INJTIME   16'h0032
`define BRK_RST_SCSTART   16'h0000
`define BRK_RST_SCSTOP    16'h0032
`define BRK_RST_FLUX      16'h0000
`define BRK_STOP_SCALE    32'h0000000A
`define BRK_CTRL_SEL      0
`define BRK_CTRL_METH_LO  1
`define BRK_CTRL_MODE_LO  3
`endif

// ==== pkg/brk_pkg.sv ====
// Types of the braking and power-up run sequencer
package brk_pkg;
  // Sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    BRK_PWRUP   = 3'h0,
    BRK_IDLE    = 3'h1,
    BRK_STARTB  = 3'h3,
    BRK_RUN     = 3'h2,
    BRK_RAMP    = 3'h6,
    BRK_STOPB   = 3'h7,
    BRK_LOCKOUT = 3'h4
  } brk_state_type;
  // Control modes
  typedef enum logic [1:0] {
    BRK_VF = 2'h0, BRK_VECTOR = 2'h1, BRK_MAGNET = 2'h2, BRK_RSVD = 2'h3
  } brk_mode_type;
  // Power stage commands
  typedef struct packed {
    logic       drive_on;
    logic       ramp_down;
    logic       dc_inject;
    logic       phase_short;
    logic       carrier_1k;
    logic       flux_boost;
    logic [6:0] inj_level;
    logic [9:0] flux_level;
    logic       run_led;
  } brk_out_type;
endpackage : brk_pkg

// ==== rtl/brk_seq.sv ====
// Braking and power-up run sequencer with Avalon-MM registers
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`include "brk_consts.svh"
module brk_seq #(
  parameter int TICK_CYCLES = `BRK_TICK_CYCLES  // 10 ms timebase
) (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 run_pin,
  input  wire logic                 startup_done,
  input  wire logic [15:0]          output_freq,
  output brk_pkg::brk_out_type      stage
);
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // Limit a written value to its range
  function automatic logic [15:0] clampv(input logic [31:0] v,
                                          input logic [15:0] lim);
    clampv = (v > {16'h0000, lim}) ? lim : v[15:0];
  endfunction : clampv

  // Stop injection ticks from frequency ratio
  function automatic logic [15:0] dc_stop_ticks(input logic [15:0] t,
                                                input logic [15:0] f,
                                                input logic [15:0] fm);
    logic [31:0] p;
    p = {16'h0000, t} * `BRK_STOP_SCALE * {16'h0000, f};
    if (fm == 16'h0000) begin
      dc_stop_ticks = t;
    end else begin
      p = p / {16'h0000, fm};
      dc_stop_ticks = (p > 32'h0000FFFF) ? 16'hFFFF : p[15:0];
    end
  endfunction : dc_stop_ticks

  // ----------------------------------------------------------
  // Settings
  // ----------------------------------------------------------
  logic                  pwr_sel_r;     // Power-up run accept
  logic [1:0]            meth_r;        // Stopping method
  brk_pkg::brk_mode_type mode_r;        // Control mode
  logic [15:0]           brkfreq_r;     // Brake start, 0.1 Hz
  logic [15:0]           minfreq_r;     // Minimum output, 0.1 Hz
  logic [15:0]           maxfreq_r;     // Maximum output, 0.1 Hz
  logic [15:0]           injlvl_r;      // Injection current, %
  logic [15:0]           injstart_r;    // Start injection, 10 ms
  logic [15:0]           injstop_r;     // Stop injection, 10 ms
  logic [15:0]           flux_r;        // Flux boost, %
  logic [15:0]           scstart_r;     // Start phase short, 10 ms
  logic [15:0]           scstop_r;      // Stop phase short, 10 ms
  // Bus
  logic                  ack_r;         // Second cycle of access
  logic                  wr_go;         // Write commits now
  // Sequencer
  logic                  run_m_r;       // Sync stage one
  logic                  run_s_r;       // Synchronised run
  brk_pkg::brk_state_type st_r;
  brk_pkg::brk_state_type st_nxt;
  logic [15:0]           tmr_r;         // Brake timer, ticks
  logic [15:0]           tmr_nxt;
  logic                  tmr_ld;
  logic [31:0]           tick_cnt_r;
  logic                  tick;          // 10 ms pulse
  logic [7:0]            flash_cnt_r;
  logic                  flash_tgl;     // Fast flash edge
  logic                  led_r;
  logic                  pm;            // Magnet motor mode
  logic [15:0]           thr;           // Effective stop threshold
  logic                  flux_on;
  logic [15:0]           start_t;       // Start brake time for this motor
  logic [15:0]           stop_t;        // Stop brake time for this motor

  assign pm  = (mode_r == brk_pkg::BRK_MAGNET);
  assign start_t = pm ? scstart_r : injstart_r;  // [RULE_06]
  assign stop_t  = pm ? scstop_r : injstop_r;
  // Larger of start frequency and minimum
  assign thr = (brkfreq_r < minfreq_r) ? minfreq_r : brkfreq_r;  // [RULE_08]

  // ----------------------------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------------------------
  // Access held one cycle so readdata is registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r & (avs_byteenable == 4'hF);

  // Acknowledge toggle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // Read mux, unmapped reads zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_r) begin
      case (avs_address)
        `BRK_A_CTRL:     avs_readdata <= {27'h0, mode_r, meth_r, pwr_sel_r};
        `BRK_A_BRKFREQ:  avs_readdata <= {16'h0, brkfreq_r};
        `BRK_A_MINFREQ:  avs_readdata <= {16'h0, minfreq_r};
        `BRK_A_MAXFREQ:  avs_readdata <= {16'h0, maxfreq_r};
        `BRK_A_INJLVL:   avs_readdata <= {16'h0, injlvl_r};
        `BRK_A_INJSTART: avs_readdata <= {16'h0, injstart_r};
        `BRK_A_INJSTOP:  avs_readdata <= {16'h0, injstop_r};
        `BRK_A_FLUX:     avs_readdata <= {16'h0, flux_r};
        `BRK_A_SCSTART:  avs_readdata <= {16'h0, scstart_r};
        `BRK_A_SCSTOP:   avs_readdata <= {16'h0, scstop_r};
        `BRK_A_STATUS:   avs_readdata <= {11'h0, tmr_r, run_s_r, led_r, st_r};
        default:         avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Setting writes, out-of-range values clamp
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_sel_r  <= 1'b0;                                 // [RULE_04]
      meth_r     <= 2'h0;
      mode_r     <= brk_pkg::BRK_VF;
      brkfreq_r  <= `BRK_RST_BRKFREQ;                     // [RULE_07]
      minfreq_r  <= `BRK_RST_MINFREQ;
      maxfreq_r  <= `BRK_RST_MAXFREQ;
      injlvl_r   <= `BRK_RST_INJLVL;                      // [RULE_10]
      injstart_r <= `BRK_RST_INJTIME;                     // [RULE_12]
      injstop_r  <= `BRK_RST_INJTIME;                     // [RULE_13]
      flux_r     <= `BRK_RST_FLUX;                        // [RULE_14]
      scstart_r  <= `BRK_RST_SCSTART;                     // [RULE_17]
      scstop_r   <= `BRK_RST_SCSTOP;                      // [RULE_18]
    end else if (wr_go) begin
      case (avs_address)
        `BRK_A_CTRL: begin
          pwr_sel_r <= avs_writedata[`BRK_CTRL_SEL];      // [RULE_04]
          meth_r    <= avs_writedata[`BRK_CTRL_METH_LO +: 2];
          mode_r    <= brk_pkg::brk_mode_type'(avs_writedata[`BRK_CTRL_MODE_LO +: 2]);
        end
        `BRK_A_BRKFREQ:  brkfreq_r  <= clampv(avs_writedata, `BRK_MAX_BRKFREQ);
        // Minimum never above maximum
        `BRK_A_MINFREQ:  minfreq_r  <= clampv(avs_writedata, maxfreq_r);   // [RULE_09]
        `BRK_A_MAXFREQ: begin
          maxfreq_r <= clampv(avs_writedata, `BRK_MAX_FREQ_LIM);
          if ({16'h0, minfreq_r} > avs_writedata) begin
            minfreq_r <= clampv(avs_writedata, `BRK_MAX_FREQ_LIM);         // [RULE_09]
          end
        end
        `BRK_A_INJLVL:   injlvl_r   <= clampv(avs_writedata, `BRK_MAX_INJLVL);  // [RULE_10]
        `BRK_A_INJSTART: injstart_r <= clampv(avs_writedata, `BRK_MAX_INJTIME); // [RULE_12]
        `BRK_A_INJSTOP:  injstop_r  <= clampv(avs_writedata, `BRK_MAX_INJTIME); // [RULE_13]
        `BRK_A_FLUX:     flux_r     <= clampv(avs_writedata, `BRK_MAX_FLUX);    // [RULE_14]
        `BRK_A_SCSTART:  scstart_r  <= clampv(avs_writedata, `BRK_MAX_SCTIME);  // [RULE_17]
        `BRK_A_SCSTOP:   scstop_r   <= clampv(avs_writedata, `BRK_MAX_SCTIME);  // [RULE_18]
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Run input synchroniser and timebase
  // ----------------------------------------------------------
  // Run comes from a terminal, two flops first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_m_r <= 1'b0;
      run_s_r <= 1'b0;
    end else begin
      run_m_r <= run_pin;
      run_s_r <= run_m_r;
    end
  end

  // 10 ms tick divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_r <= 32'h00000000;
    end else if (tick) begin
      tick_cnt_r <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end
  end
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // Fast flash divider, free running on ticks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_cnt_r <= 8'h00;
    end else if (tick) begin
      flash_cnt_r <= flash_tgl ? 8'h00 : flash_cnt_r + 8'h01;
    end
  end
  assign flash_tgl = tick && (flash_cnt_r == `BRK_FLASH_TICKS - 8'h01);

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  // Next state and timer load
  always_comb begin
    st_nxt  = st_r;
    tmr_ld  = 1'b0;
    tmr_nxt = 16'h0000;
    case (st_r)
      brk_pkg::BRK_PWRUP: begin
        // Decide only once start-up is complete
        if (startup_done) begin
          if (run_s_r && !pwr_sel_r) begin
            st_nxt = brk_pkg::BRK_LOCKOUT;                // [RULE_01]
          end else if (run_s_r) begin
            // Zero start time means no start brake at all
            st_nxt  = (start_t == 16'h0000) ? brk_pkg::BRK_RUN :
                      brk_pkg::BRK_STARTB;                       // [RULE_03]
            tmr_ld  = 1'b1;
            tmr_nxt = start_t;
          end else begin
            st_nxt = brk_pkg::BRK_IDLE;
          end
        end
      end
      brk_pkg::BRK_LOCKOUT: begin
        // Release of run ends refusal
        if (!run_s_r) begin
          st_nxt = brk_pkg::BRK_IDLE;                     // [RULE_01]
        end
      end
      brk_pkg::BRK_IDLE: begin
        if (run_s_r) begin
          // No one-clock brake pulse when the time is zero
          st_nxt  = (start_t == 16'h0000) ? brk_pkg::BRK_RUN :
                    brk_pkg::BRK_STARTB;                         // [RULE_12] [RULE_17]
          tmr_ld  = 1'b1;
          tmr_nxt = start_t;                                     // [RULE_06]
        end
      end
      brk_pkg::BRK_STARTB: begin
        // Zero time passes straight to run
        if (tmr_r == 16'h0000) begin
          st_nxt = brk_pkg::BRK_RUN;                      // [RULE_20]
        end
      end
      brk_pkg::BRK_RUN: begin
        if (!run_s_r) begin
          if (meth_r == 2'h0) begin
            st_nxt = brk_pkg::BRK_RAMP;                   // [RULE_05]
          end else if (meth_r == 2'h2 && !pm) begin
            st_nxt  = brk_pkg::BRK_STOPB;
            tmr_ld  = 1'b1;
            tmr_nxt = dc_stop_ticks(injstop_r, output_freq, maxfreq_r);  // [RULE_19]
          end else begin
            st_nxt = brk_pkg::BRK_IDLE;
          end
        end
      end
      brk_pkg::BRK_RAMP: begin
        if (run_s_r) begin
          st_nxt = brk_pkg::BRK_RUN;
        end else if (output_freq < thr) begin
          st_nxt  = (stop_t == 16'h0000) ? brk_pkg::BRK_IDLE :
                    brk_pkg::BRK_STOPB;                          // [RULE_07] [RULE_18]
          tmr_ld  = 1'b1;
          tmr_nxt = stop_t;                                      // [RULE_06]
        end
      end
      brk_pkg::BRK_STOPB: begin
        if (tmr_r == 16'h0000) begin
          st_nxt = brk_pkg::BRK_IDLE;                     // [RULE_20]
        end
      end
      default: st_nxt = brk_pkg::BRK_PWRUP;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= brk_pkg::BRK_PWRUP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Brake timer, counts down on ticks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_r <= 16'h0000;
    end else if (tmr_ld) begin
      tmr_r <= tmr_nxt;
    end else if (tick && tmr_r != 16'h0000) begin
      tmr_r <= tmr_r - 16'h0001;
    end
  end

  // Run indicator: fast flash while refusing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      led_r <= 1'b0;
    end else if (st_r == brk_pkg::BRK_LOCKOUT) begin
      led_r <= flash_tgl ? ~led_r : led_r;                // [RULE_02]
    end else begin
      led_r <= (st_r != brk_pkg::BRK_IDLE) && (st_r != brk_pkg::BRK_PWRUP);
    end
  end

  // Flux boost only under induction start injection
  assign flux_on = (st_nxt == brk_pkg::BRK_STARTB) && !pm &&
                   (output_freq < minfreq_r) && (flux_r != 16'h0000);  // [RULE_15]

  // ----------------------------------------------------------
  // Power stage outputs, registered
  // ----------------------------------------------------------
  // Outputs follow next state so they line up with st_r
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= '0;
    end else begin
      stage.drive_on    <= (st_nxt == brk_pkg::BRK_RUN) ||
                           (st_nxt == brk_pkg::BRK_RAMP);
      stage.ramp_down   <= (st_nxt == brk_pkg::BRK_RAMP);
      // Braking states pick current or phase short
      stage.dc_inject   <= !pm && ((st_nxt == brk_pkg::BRK_STARTB) ||
                           (st_nxt == brk_pkg::BRK_STOPB));            // [RULE_06]
      stage.phase_short <= pm && ((st_nxt == brk_pkg::BRK_STARTB) ||
                           (st_nxt == brk_pkg::BRK_STOPB));            // [RULE_16]
      // High injection current overheats at full carrier
      stage.carrier_1k  <= (injlvl_r > `BRK_CARRIER_LVL);              // [RULE_11]
      stage.flux_boost  <= flux_on;                                    // [RULE_15]
      stage.inj_level   <= injlvl_r[6:0];                              // [RULE_10]
      stage.flux_level  <= flux_on ? flux_r[9:0] : 10'h000;            // [RULE_14]
      // Refusal shows only the flash, no steady blip on entry
      stage.run_led     <= (st_nxt == brk_pkg::BRK_LOCKOUT) ? led_r :
                           (st_nxt != brk_pkg::BRK_IDLE) && (st_nxt != brk_pkg::BRK_PWRUP);
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  property p_refuse;
    @(posedge clk) disable iff (!arst_n)
    (st_r == brk_pkg::BRK_PWRUP && startup_done && run_s_r && !pwr_sel_r)
      |=> (st_r == brk_pkg::BRK_LOCKOUT) && !stage.drive_on && !stage.dc_inject;
  endproperty
  a_refuse: assert property (p_refuse) else $error("power-up run not refused"); // [RULE_01]

  property p_flash;
    @(posedge clk) disable iff (!arst_n)
    (st_r == brk_pkg::BRK_LOCKOUT && flash_tgl) |=> (led_r != $past(led_r));
  endproperty
  a_flash: assert property (p_flash) else $error("indicator did not flash"); // [RULE_02]

  property p_accept;
    @(posedge clk) disable iff (!arst_n)
    (st_r == brk_pkg::BRK_PWRUP && startup_done && run_s_r && pwr_sel_r &&
     start_t != 16'h0000)
      |=> (st_r == brk_pkg::BRK_STARTB) ##[0:1] (st_r != brk_pkg::BRK_LOCKOUT);
  endproperty
  a_accept: assert property (p_accept) else $error("power-up run not accepted"); // [RULE_03]

  property p_ramp;
    @(posedge clk) disable iff (!arst_n)
    (st_r == brk_pkg::BRK_RUN && !run_s_r && meth_r == 2'h0)
      |=> (st_r == brk_pkg::BRK_RAMP) && stage.ramp_down;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp stop not entered"); // [RULE_05]

  property p_brake_kind;
    @(posedge clk) disable iff (!arst_n)
    (stage.dc_inject |-> !pm) and (stage.phase_short |-> pm);
  endproperty
  a_brake_kind: assert property (p_brake_kind) else $error("wrong brake kind"); // [RULE_06]

  property p_thresh;
    @(posedge clk) disable iff (!arst_n)
    (st_r == brk_pkg::BRK_RAMP && !run_s_r && output_freq < brkfreq_r &&
     output_freq < minfreq_r && stop_t != 16'h0000) |=> (st_r == brk_pkg::BRK_STOPB);
  endproperty
  a_thresh: assert property (p_thresh) else $error("stop braking late"); // [RULE_08]

  property p_minclamp;
    @(posedge clk) disable iff (!arst_n)
    minfreq_r <= maxfreq_r;
  endproperty
  a_minclamp: assert property (p_minclamp) else $error("minimum above maximum"); // [RULE_09]

  property p_carrier;
    @(posedge clk) disable iff (!arst_n)
    $changed(injlvl_r) |-> ##1 (stage.carrier_1k == ($past(injlvl_r) > `BRK_CARRIER_LVL));
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier not forced"); // [RULE_11]

  property p_flux;
    @(posedge clk) disable iff (!arst_n)
    stage.flux_boost |-> (st_r == brk_pkg::BRK_STARTB) && stage.dc_inject;
  endproperty
  a_flux: assert property (p_flux) else $error("flux boost outside start"); // [RULE_15]

  property p_timer_end;
    @(posedge clk) disable iff (!arst_n)
    (st_r == brk_pkg::BRK_STOPB && tmr_r == 16'h0000)
      |=> (st_r == brk_pkg::BRK_IDLE) && !stage.dc_inject && !stage.phase_short;
  endproperty
  a_timer_end: assert property (p_timer_end) else $error("braking did not end"); // [RULE_20]

endmodule : brk_seq

// ==== test/brk_far_side.sv ====
// Far-side model: run command source, start-up signal and motor speed
`timescale 1ns/10ps
module brk_far_side (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            run_req,
  input  wire logic            power_ok,
  input  brk_pkg::brk_out_type stage,
  output logic                 run_pin,
  output logic                 startup_done,
  output logic      [15:0]     output_freq
);
  // ----------------------------------------
  // Motor model
  // ----------------------------------------
  assign run_pin = run_req;  // Level from the run contact
  // Speed climbs to 4 Hz while driven, falls 0.1 Hz a clock while ramping
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      startup_done <= 1'b0;
      output_freq  <= 16'h0000;
    end else begin
      startup_done <= power_ok;  // Start-up ends one clock after supply is good
      if (stage.ramp_down && output_freq != 16'h0000) begin
        output_freq <= output_freq - 16'h0001;
      end else if (stage.drive_on && !stage.ramp_down && output_freq < 16'h0028) begin
        output_freq <= output_freq + 16'h0001;
      end
    end
  end
endmodule : brk_far_side

// ==== test/brk_seq_tb.sv ====
// Self-checking bench of the braking and power-up run sequencer
`timescale 1ns/10ps
`include "brk_consts.svh"
module brk_seq_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, arst_n, run_req, power_ok, avs_read, avs_write, run_pin, startup_done, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] output_freq;
  brk_pkg::brk_out_type stage;
  int fails, check_count, cyc;
  // Short tick keeps braking phases to tens of clocks
  brk_seq #(.TICK_CYCLES(10)) brk_seq_i (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(4'hF), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .run_pin(run_pin), .startup_done(startup_done),
    .output_freq(output_freq), .stage(stage));
  brk_far_side brk_far_side_i (.clk(clk), .arst_n(arst_n), .run_req(run_req),
    .power_ok(power_ok), .stage(stage), .run_pin(run_pin), .startup_done(startup_done),
    .output_freq(output_freq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, an unmapped read and two clamped writes
  task automatic t_regs();
    logic [5:0]  a [11] = '{`BRK_A_CTRL, `BRK_A_BRKFREQ, `BRK_A_INJLVL, `BRK_A_INJSTART,
      `BRK_A_INJSTOP, `BRK_A_FLUX, `BRK_A_SCSTART, `BRK_A_SCSTOP, 6'h2C, `BRK_A_MINFREQ,
      `BRK_A_MAXFREQ};
    logic [31:0] e [11] = '{32'h0, 32'h5, 32'h32, 32'h32, 32'h32, 32'h0, 32'h0, 32'h32, 32'h0,
      32'hF, 32'h258};
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, a[i], 32'h0);
      chk(q, e[i]);
    end
    bus(1'b1, `BRK_A_INJLVL, 32'h64);
    bus(1'b0, `BRK_A_INJLVL, 32'h0);
    chk(q, 32'h4B);
    bus(1'b1, `BRK_A_MINFREQ, 32'h1000);
    bus(1'b0, `BRK_A_MINFREQ, 32'h0);
    chk(q, 32'h258);
    bus(1'b1, `BRK_A_MINFREQ, 32'hF);
    $display("test regs done");
  endtask : t_regs
  // Run held through power-up is refused and flashes the indicator
  task automatic t_lockout();
    int n;
    logic led, bad;
    n = 0;
    bad = 1'b0;
    power_ok <= 1'b1;
    led = stage.run_led;
    repeat (300) begin
      @(posedge clk);
      if (stage.run_led !== led) n++;
      led = stage.run_led;
      if (stage.drive_on !== 1'b0 || stage.dc_inject !== 1'b0) bad = 1'b1;
    end
    chk(bad, 1'b0);
    chk(n >= 2, 1'b1);
    $display("test lockout done");
  endtask : t_lockout
  // Cycled run: start injection with boost, then ramp stop and stop injection
  task automatic t_inject();
    int n;
    bus(1'b1, `BRK_A_INJLVL, 32'h3C);
    bus(1'b1, `BRK_A_INJSTART, 32'h2);
    bus(1'b1, `BRK_A_INJSTOP, 32'h3);
    bus(1'b1, `BRK_A_FLUX, 32'h64);
    run_req <= 1'b0;
    repeat (10) @(posedge clk);
    run_req <= 1'b1;
    while (stage.dc_inject !== 1'b1) @(posedge clk);
    chk(stage.carrier_1k, 1'b1);
    chk(stage.inj_level, 7'h3C);
    chk(stage.flux_level, 10'h064);
    while (stage.drive_on !== 1'b1) @(posedge clk);
    chk(stage.dc_inject, 1'b0);
    chk(stage.flux_level, 10'h000);
    while (output_freq !== 16'h0028) @(posedge clk);
    run_req <= 1'b0;
    while (stage.dc_inject !== 1'b1) @(posedge clk);
    chk(output_freq < 16'h000F && output_freq > 16'h0008, 1'b1);
    n = 0;
    while (stage.dc_inject === 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 20 && n <= 31, 1'b1);
    chk(stage.drive_on, 1'b0);
    $display("test inject done");
  endtask : t_inject
  // Injection stop method: brake time follows speed ratio, carrier at its boundary
  task automatic t_dcstop();
    int n;
    bus(1'b1, `BRK_A_CTRL, 32'h4);
    bus(1'b1, `BRK_A_INJLVL, 32'h32);
    run_req <= 1'b1;
    while (output_freq !== 16'h0028) @(posedge clk);
    chk(stage.carrier_1k, 1'b0);
    run_req <= 1'b0;
    while (stage.dc_inject !== 1'b1) @(posedge clk);
    chk(stage.ramp_down, 1'b0);
    n = 0;
    while (stage.dc_inject === 1'b1) begin
      @(posedge clk);
      n++;
    end
    // 3 x 10 x 40 / 600 gives 2 ticks of ten clocks
    chk(n >= 12 && n <= 21, 1'b1);
    $display("test dcstop done");
  endtask : t_dcstop
  // Magnet motor, power-up run accepted, phase short at start
  task automatic t_short();
    arst_n <= 1'b0;
    power_ok <= 1'b0;
    run_req <= 1'b1;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b1, `BRK_A_CTRL, 32'h11);
    bus(1'b1, `BRK_A_SCSTART, 32'h2);
    power_ok <= 1'b1;
    while (stage.phase_short !== 1'b1) @(posedge clk);
    chk(stage.dc_inject, 1'b0);
    while (stage.drive_on !== 1'b1) @(posedge clk);
    chk(stage.phase_short, 1'b0);
    $display("test short done");
  endtask : t_short
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run needs under a thousand clocks; ceiling well above that
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    {fails, check_count, cyc} = '0;
    {avs_read, avs_write, power_ok} = '0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    run_req = 1'b1;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_lockout();
    t_inject();
    t_dcstop();
    t_short();
    print_verdict();
  end
endmodule : brk_seq_tb
